// >>> hdl/vco_cal_pkg.sv
package vco_cal_pkg;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	// register indexes, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_UPDATE = 10'h00F;
	localparam logic [IDX_W-1:0] IDX_STATUS = 10'h020;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h021;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h022;
	localparam logic [IDX_W-1:0] IDX_CTRL = 10'h100;
	localparam logic [IDX_W-1:0] IDX_LOOP = 10'h101;
	localparam logic [IDX_W-1:0] IDX_NDIV = 10'h107;
	localparam logic [IDX_W-1:0] IDX_AUXDIV = 10'h108;
	localparam int CTRL_CAL_BIT = 3;
	localparam int LOOP_LSB = 1;
	localparam int LOOP_MSB = 2;
	localparam int STAT_LOCK_BIT = 0;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_BAND_LSB = 8;
	localparam logic [7:0] UPDATE_KEY = 8'h01;
	localparam logic [1:0] LOOP_MODE0 = 2'h0;
	localparam logic [1:0] LOOP_MODE1 = 2'h1;
	localparam logic [1:0] LOOP_MODE2 = 2'h2;
	localparam logic [7:0] NDIV_RST = 8'h01;
	localparam logic [7:0] AUXDIV_RST = 8'h01;
	localparam logic [15:0] LOR_BYPASS_DIV = 16'h0200;
	localparam int CAL_PFD_CYCLES = 98500;
	localparam int LOCK_PFD_CYCLES = 65500;
	localparam int LOCK_PPM = 16;
	localparam int PPM_SCALE = 1000000;
	localparam int BAND_W = 8;
	localparam int SYNC_W = 3;
	localparam int SYNC_LOSS = 2;
	localparam int SYNC_FB = 1;
	localparam int SYNC_REF = 0;
	typedef struct packed {
		logic lock_loss;
		logic lock_gain;
		logic cal_done;
	} irq_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT_REF = 2'b01,
		ST_SEARCH = 2'b10,
		ST_DONE = 2'b11
	} cal_state_t;
endpackage

// >>> hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o,
	output logic [W-1:0] rise_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			// s1 feeds only s2, a level changes once s2 and s3 agree
			always_ff @(posedge clk_i)
			begin
				s1_r[g] <= pin_i[g];
				s2_r[g] <= s1_r[g];
				s3_r[g] <= s2_r[g];
				// level tracks the pin in reset, so a high pin shows no false low after it
				if (!rst_n_i)
				begin
					level_o[g] <= s3_r[g];
					rise_o[g] <= 1'b0;
				end
				else
				begin
					rise_o[g] <= (s2_r[g] == s3_r[g]) && s3_r[g] && !level_o[g];
					if (s2_r[g] == s3_r[g])
						level_o[g] <= s3_r[g];
				end
			end
		end
	endgenerate
endmodule

// >>> hdl/freq_lock_detect.sv
`timescale 1ns/1ns
module freq_lock_detect
	import vco_cal_pkg::*;
#(
	parameter int WINDOW = LOCK_PFD_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic ref_tick_i,
	input wire logic fb_tick_i,
	output logic lock_o
);
	localparam int CW = $clog2(WINDOW + 1) + 1;
	localparam logic [CW-1:0] LAST = CW'(WINDOW - 1);
	localparam logic [63:0] LIMIT = 64'(LOCK_PPM) * 64'(WINDOW);
	localparam logic [63:0] SCALE = 64'(PPM_SCALE);
	logic [CW-1:0] ref_cnt_r;
	logic [CW-1:0] fb_cnt_r;
	logic [CW-1:0] diff;
	always_comb
	begin
		diff = (fb_cnt_r > ref_cnt_r) ? fb_cnt_r - ref_cnt_r : ref_cnt_r - fb_cnt_r;
	end
	// window counted in reference edges at the phase detector
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !run_i)
		begin
			ref_cnt_r <= '0;
			fb_cnt_r <= '0;
		end
		else if (ref_tick_i && ref_cnt_r == LAST)
		begin
			ref_cnt_r <= '0;
			fb_cnt_r <= '0;
		end
		else
		begin
			if (ref_tick_i)
				ref_cnt_r <= ref_cnt_r + 1'b1;
			if (fb_tick_i)
				fb_cnt_r <= fb_cnt_r + 1'b1;
		end
	end
	// lock drops at once when the loop is taken away for calibration
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !run_i)
			lock_o <= 1'b0;
		else if (ref_tick_i && ref_cnt_r == LAST)
			lock_o <= (64'(diff) * SCALE) < LIMIT;
	end
endmodule

// >>> hdl/vco_calibration_controller.sv
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ns
// Function
// - calibrate against reference, wait for valid reference
// - loop 1, divide >= 512: skip loss gating
// - start bit set to one starts calibration
// - start bit sticks; needs zero before next start
// - status busy bit high while calibrating
// - first calibration holds distribution until busy falls
// - calibration lasts about 98,500 phase-detector cycles
// - calibration stops primary and zero-delay dividers
// - loop 2 calibrates as loop 0, then restores
// - lock when average difference below 16 ppm
// - lock evaluation takes about 65,500 cycles
// - calibration resets both oscillator output dividers
module vco_calibration_controller
	import vco_cal_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_PFD_CYCLES,
	parameter int LOCK_CYCLES = LOCK_PFD_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic ref_clk_i,
	input wire logic fb_clk_i,
	input wire logic reference_loss_flag_i,
	output logic irq_o,
	output logic cal_busy_o,
	output logic lock_o,
	output logic [1:0] loop_mode_o,
	output logic dist_sync_o,
	output logic vco_div_sync_o,
	output logic [BAND_W-1:0] vco_band_o
);
	localparam int CW = $clog2(CAL_CYCLES + 1);
	localparam int BW = $clog2(BAND_W);
	localparam logic [CW-1:0] STEP_LAST = CW'(CAL_CYCLES / BAND_W - 1);
	localparam logic [BAND_W-1:0] BAND_MID = BAND_W'(1) << (BAND_W - 1);
	localparam logic [BW-1:0] BIT_TOP = BW'(BAND_W - 1);
	logic [SYNC_W-1:0] pin_level;
	logic [SYNC_W-1:0] pin_rise;
	logic ref_rise;
	logic fb_rise;
	logic ref_lost;
	logic det_lock;
	logic acc;
	logic wr_pend_r;
	logic rd_pend_r;
	logic hi_ok_r;
	logic [IDX_W-1:0] idx_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic we;
	logic start_stage_r;
	logic start_app_r;
	logic [1:0] mode_stage_r;
	logic [1:0] mode_app_r;
	logic [7:0] ndiv_r;
	logic [7:0] aux_r;
	logic update_wr;
	logic start_pend_r;
	cal_state_t state_r;
	cal_state_t state_nxt;
	logic [CW-1:0] step_ref_r;
	logic [CW-1:0] step_fb_r;
	logic [BW-1:0] bit_idx_r;
	logic [BAND_W-1:0] band_r;
	logic step_end;
	logic ref_ok;
	logic lor_bypass;
	logic busy_r;
	logic busy_nxt;
	logic dist_sync_r;
	logic [1:0] loop_mode_r;
	irq_t irq_stat_r;
	irq_t irq_mask_r;
	irq_t irq_set;
	irq_t irq_clr;
	irq_t irq_stat_nxt;
	logic lock_prev_r;
	logic irq_r;
	pin_sync #(
		.W(SYNC_W)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.pin_i({reference_loss_flag_i, fb_clk_i, ref_clk_i}),
		.level_o(pin_level),
		.rise_o(pin_rise)
	);

	assign ref_rise = pin_rise[SYNC_REF];
	assign fb_rise = pin_rise[SYNC_FB];
	assign ref_lost = pin_level[SYNC_LOSS];
	// lock detector only runs on a closed loop, never during calibration
	freq_lock_detect #(
		.WINDOW(LOCK_CYCLES)
	) u_lock (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.run_i(!busy_r),
		.ref_tick_i(ref_rise),
		.fb_tick_i(fb_rise),
		.lock_o(det_lock)
	);

	// bus: writes zero wait, reads one wait so a write just before is seen
	assign acc = hsel_i && htrans_i[1] && hready_i;
	assign we = wr_pend_r && hi_ok_r;
	assign update_wr = we && idx_r == IDX_UPDATE && hwdata_i[7:0] == UPDATE_KEY;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			hi_ok_r <= 1'b0;
			idx_r <= '0;
			hreadyout_r <= 1'b1;
		end
		else
		begin
			wr_pend_r <= acc && hwrite_i;
			rd_pend_r <= acc && !hwrite_i;
			hreadyout_r <= !(acc && !hwrite_i);
			if (acc)
			begin
				idx_r <= haddr_i[ADDR_W-1:2];
				hi_ok_r <= haddr_i[31:ADDR_W] == '0;
			end
		end
	end

	always_comb
	begin
		rd_mux = '0;
		unique case (idx_r)
			IDX_CTRL: rd_mux[CTRL_CAL_BIT] = start_stage_r;
			IDX_LOOP: rd_mux[LOOP_MSB:LOOP_LSB] = mode_stage_r;
			IDX_NDIV: rd_mux[7:0] = ndiv_r;
			IDX_AUXDIV: rd_mux[7:0] = aux_r;
			IDX_STATUS:
			begin
				rd_mux[STAT_LOCK_BIT] = lock_o;
				rd_mux[STAT_BUSY_BIT] = busy_r;
				rd_mux[STAT_BAND_LSB +: BAND_W] = band_r;
			end
			IDX_IRQ_STAT: rd_mux[$bits(irq_t)-1:0] = irq_stat_r;
			IDX_IRQ_MASK: rd_mux[$bits(irq_t)-1:0] = irq_mask_r;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			hrdata_r <= '0;
		else if (rd_pend_r)
			hrdata_r <= hi_ok_r ? rd_mux : '0;
	end

	// staged start and loop mode, taken over only on an update write; the divider registers act at once
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			start_stage_r <= 1'b0;
			mode_stage_r <= LOOP_MODE0;
			ndiv_r <= NDIV_RST;
			aux_r <= AUXDIV_RST;
		end
		else if (we)
		begin
			if (idx_r == IDX_CTRL)
				start_stage_r <= hwdata_i[CTRL_CAL_BIT];
			if (idx_r == IDX_LOOP)
				mode_stage_r <= hwdata_i[LOOP_MSB:LOOP_LSB];
			if (idx_r == IDX_NDIV)
				ndiv_r <= hwdata_i[7:0];
			if (idx_r == IDX_AUXDIV)
				aux_r <= hwdata_i[7:0];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			start_app_r <= 1'b0;
			mode_app_r <= LOOP_MODE0;
		end
		else if (update_wr)
		begin
			start_app_r <= start_stage_r;
			mode_app_r <= mode_stage_r;
		end
	end

	// a start that stays at one never retriggers; a reset always calibrates
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			start_pend_r <= 1'b1;
		else if (update_wr && start_stage_r && !start_app_r)
			start_pend_r <= 1'b1;
		else if (state_r == ST_IDLE)
			start_pend_r <= 1'b0;
	end

	// low reference rates leave the loss flag set, so it cannot gate
	assign lor_bypass = mode_app_r == LOOP_MODE1 && (16'(ndiv_r) * 16'(aux_r)) >= LOR_BYPASS_DIV;
	assign ref_ok = ref_rise && (lor_bypass || !ref_lost);
	assign step_end = ref_rise && step_ref_r == STEP_LAST;

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:
				if (start_pend_r)
					state_nxt = ST_WAIT_REF;
			ST_WAIT_REF:
				if (ref_ok)
					state_nxt = ST_SEARCH;
			ST_SEARCH:
				if (step_end && bit_idx_r == '0)
					state_nxt = ST_DONE;
			ST_DONE:
				state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// band search: one bit per step, feedback edges against reference edges
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			step_ref_r <= '0;
			step_fb_r <= '0;
			bit_idx_r <= BIT_TOP;
			band_r <= BAND_MID;
		end
		else if (state_r == ST_WAIT_REF)
		begin
			step_ref_r <= '0;
			step_fb_r <= '0;
			bit_idx_r <= BIT_TOP;
			band_r <= BAND_MID;
		end
		else if (state_r == ST_SEARCH)
		begin
			if (step_end)
			begin
				step_ref_r <= '0;
				step_fb_r <= '0;
				if (step_fb_r > step_ref_r)
					band_r[bit_idx_r] <= 1'b0;
				if (bit_idx_r != '0)
				begin
					band_r[bit_idx_r - 1'b1] <= 1'b1;
					bit_idx_r <= bit_idx_r - 1'b1;
				end
			end
			else
			begin
				if (ref_rise)
					step_ref_r <= step_ref_r + 1'b1;
				if (fb_rise)
					step_fb_r <= step_fb_r + 1'b1;
			end
		end
	end

	assign busy_nxt = state_nxt == ST_WAIT_REF || state_nxt == ST_SEARCH;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			busy_r <= 1'b0;
			loop_mode_r <= LOOP_MODE0;
		end
		else
		begin
			busy_r <= busy_nxt;
			// divider chain stops during calibration, so loop 2 has no feedback
			loop_mode_r <= (busy_nxt && mode_app_r == LOOP_MODE2) ? LOOP_MODE0 : mode_app_r;
		end
	end

	// distribution held only through the first calibration after reset
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			dist_sync_r <= 1'b1;
		else if (state_r == ST_SEARCH && state_nxt == ST_DONE)
			dist_sync_r <= 1'b0;
	end

	// interrupts: set wins over a same-cycle clear
	always_comb
	begin
		irq_set.cal_done = state_r == ST_DONE;
		irq_set.lock_gain = det_lock && !lock_prev_r;
		irq_set.lock_loss = !det_lock && lock_prev_r;
		irq_clr = '0;
		if (we && idx_r == IDX_IRQ_STAT)
			irq_clr = hwdata_i[$bits(irq_t)-1:0];
		irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			lock_prev_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			irq_stat_r <= irq_stat_nxt;
			lock_prev_r <= det_lock;
			irq_r <= |(irq_stat_nxt & irq_mask_r);
			if (we && idx_r == IDX_IRQ_MASK)
				irq_mask_r <= hwdata_i[$bits(irq_t)-1:0];
		end
	end

	assign hrdata_o = hrdata_r;
	assign hreadyout_o = hreadyout_r;
	assign hresp_o = 1'b0;
	assign irq_o = irq_r;
	assign cal_busy_o = busy_r;
	assign lock_o = lock_prev_r;
	assign loop_mode_o = loop_mode_r;
	assign dist_sync_o = dist_sync_r;
	// busy holds both oscillator dividers in synchronous reset
	assign vco_div_sync_o = busy_r;
	assign vco_band_o = band_r;
endmodule

// >>> testbench/vco_calibration_controller_monitor.sv
`timescale 1ns/1ns
module vco_calibration_controller_monitor
	import vco_cal_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic cal_busy_o,
	input wire logic lock_o,
	input wire logic [1:0] loop_mode_o,
	input wire logic dist_sync_o,
	input wire logic vco_div_sync_o
);
	logic take;
	assign take = hsel_i & htrans_i[1] & hready_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_div_sync: assert property (vco_div_sync_o == cal_busy_o)
		else $error("divider sync differs from busy");
	chk_dist_release: assert property ($fell(dist_sync_o) |-> !cal_busy_o && ($past(cal_busy_o) || $past(cal_busy_o, 2)))
		else $error("distribution released without busy falling");
	chk_dist_once: assert property (!$rose(dist_sync_o))
		else $error("distribution hold came back");
	chk_loop_swap: assert property (cal_busy_o && $past(cal_busy_o) |-> loop_mode_o != LOOP_MODE2)
		else $error("loop mode 2 seen while calibrating");
	chk_lock_drop: assert property (cal_busy_o [*3] |-> !lock_o)
		else $error("lock shown during calibration");
	chk_busy_len: assert property ($rose(cal_busy_o) |-> cal_busy_o [*8])
		else $error("calibration too short");
	chk_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	chk_write_zero: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	cover property ($fell(cal_busy_o));
	cover property ($rose(lock_o));
	cover property ($fell(dist_sync_o));
endmodule
bind vco_calibration_controller vco_calibration_controller_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
	.cal_busy_o(cal_busy_o), .lock_o(lock_o), .loop_mode_o(loop_mode_o), .dist_sync_o(dist_sync_o),
	.vco_div_sync_o(vco_div_sync_o));

// >>> testbench/test_vco_calibration_controller.sv
`timescale 1ns/1ns
module test_vco_calibration_controller
	import vco_cal_pkg::*;
;
	logic clk_i, rst_n_i, hsel_i, hwrite_i, reference_loss_flag_i, ref_on, fb_fast;
	logic hreadyout_o, hresp_o, irq_o, cal_busy_o, lock_o, dist_sync_o, vco_div_sync_o;
	logic [1:0] htrans_i, loop_mode_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, q;
	logic [7:0] vco_band_o;
	logic [2:0] cnt;
	int err_total, comparisons, cycles;
	// fb at twice the reference drives every band bit low
	wire ref_clk_i = ref_on & cnt[2];
	wire fb_clk_i = ref_on & (fb_fast ? cnt[1] : cnt[2]);
	vco_calibration_controller #(.CAL_CYCLES(80), .LOCK_CYCLES(64)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .ref_clk_i(ref_clk_i), .fb_clk_i(fb_clk_i), .reference_loss_flag_i(reference_loss_flag_i),
		.irq_o(irq_o), .cal_busy_o(cal_busy_o), .lock_o(lock_o), .loop_mode_o(loop_mode_o),
		.dist_sync_o(dist_sync_o), .vco_div_sync_o(vco_div_sync_o), .vco_band_o(vco_band_o));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic finish_test;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cnt <= cnt + 3'h1;
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			err_total++;
			finish_test;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// master holds each phase until hready is sampled high
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_i); while (hreadyout_o !== 1'b1);
		q = hrdata_o;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	task automatic cal;
		xfer(1'b1, 32'h400, 32'h0);
		xfer(1'b1, 32'h03C, 32'h1);
		xfer(1'b1, 32'h400, 32'h8);
		xfer(1'b1, 32'h03C, 32'h1);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (8) @(posedge clk_i);
		do
		begin
			xfer(1'b0, 32'h080, 32'h0);
			n++;
		end
		while (q[2] !== 1'b0 && n < 500);
		if (q[2] !== 1'b0)
		begin
			err_total++;
			$display("CHECK FAILED %0t calibration never ended", $time);
		end
	endtask
	initial
	begin
		rst_n_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hwdata_i = 32'h0;
		reference_loss_flag_i = 1'b1;
		ref_on = 1'b0;
		fb_fast = 1'b1;
		cnt = 3'h0;
		cycles = 0;
		err_total = 0;
		comparisons = 0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		chk(dist_sync_o, 32'h1);
		rd(32'h41C, 32'hFF, 32'h1);
		chk(hresp_o, 32'h0);
		rd(32'h420, 32'hFF, 32'h1);
		rd(32'hFFC, 32'hFFFFFFFF, 32'h0);
		xfer(1'b1, 32'h088, 32'h0);
		ref_on <= 1'b1;
		repeat (100) @(posedge clk_i);
		rd(32'h080, 32'h4, 32'h4);
		reference_loss_flag_i <= 1'b0;
		wait_idle;
		rd(32'h080, 32'hFF04, 32'h0);
		chk(vco_band_o, 32'h0);
		chk(dist_sync_o, 32'h0);
		chk(irq_o, 32'h0);
		rd(32'h084, 32'h1, 32'h1);
		xfer(1'b1, 32'h088, 32'h7);
		rd(32'h088, 32'h7, 32'h7);
		chk(irq_o, 32'h1);
		xfer(1'b1, 32'h084, 32'h1);
		rd(32'h084, 32'h1, 32'h0);
		chk(irq_o, 32'h0);
		fb_fast <= 1'b0;
		xfer(1'b1, 32'h41C, 32'h32);
		rd(32'h41C, 32'hFF, 32'h32);
		xfer(1'b1, 32'h404, 32'h4);
		xfer(1'b1, 32'h400, 32'h8);
		repeat (10) @(posedge clk_i);
		chk(cal_busy_o, 32'h0);
		chk(loop_mode_o, 32'h0);
		xfer(1'b1, 32'h03C, 32'h1);
		repeat (8) @(posedge clk_i);
		chk(cal_busy_o, 32'h1);
		chk(loop_mode_o, 32'h0);
		wait_idle;
		chk(loop_mode_o, 32'h2);
		chk(vco_band_o, 32'hFF);
		chk(dist_sync_o, 32'h0);
		xfer(1'b1, 32'h03C, 32'h1);
		repeat (8) @(posedge clk_i);
		chk(cal_busy_o, 32'h0);
		repeat (1200) @(posedge clk_i);
		rd(32'h080, 32'h1, 32'h1);
		rd(32'h084, 32'h2, 32'h2);
		xfer(1'b1, 32'h084, 32'h6);
		rd(32'h084, 32'h6, 32'h0);
		xfer(1'b1, 32'h404, 32'h2);
		xfer(1'b1, 32'h41C, 32'h20);
		xfer(1'b1, 32'h420, 32'h10);
		reference_loss_flag_i <= 1'b1;
		cal;
		wait_idle;
		rd(32'h080, 32'h4, 32'h0);
		rd(32'h084, 32'h4, 32'h4);
		xfer(1'b1, 32'h41C, 32'h49);
		xfer(1'b1, 32'h420, 32'h07);
		cal;
		repeat (300) @(posedge clk_i);
		rd(32'h080, 32'h4, 32'h4);
		reference_loss_flag_i <= 1'b0;
		wait_idle;
		rd(32'h080, 32'h4, 32'h0);
		finish_test;
	end
endmodule
